// ### core/octmc_top.v
// Configuration bank for output regulator, wall charger, thermal guard
// and power monitor, with its serial register port slave.
// Assumes an open-drain data line resolved outside, a host clocking the
// serial line far slower than clk_sys_i, and same-clock analog status codes.
//
// Notes on behaviour
// - Codes 1..10 regulate; other codes switch output off
// - Timing multiplier codes map to x1..x16 factors
// - Multiplier resets 3 or strap; voltage resets off
// - Charger enable bit zero, resets set
// - Constant-voltage mode stops charging at threshold
// - Five-bit stop threshold code passed to charger
// - Outside charge window stops charging and disables boost
// - Outside discharge window disables output regulator only
// - Charge limits reset to d1 and 18
// - Discharge limits reset to d1 and 18
// - Guard enable bit, resets set, clear ignores limits
// - Monitor mode setting applies to channels 0..2 only
// - Window bit selects 233 or 116 ms
// - Any 116 ms tracking source forces short window
// - Bits 0..3 enable per-channel monitoring
// - Mode bit selects meter; charger always counts
`timescale 1ns/1ps
`include "octmc_defs.vh"
module octmc_top #(
   parameter [6:0] DEV_ADDR = `OCTMC_DEV_ADDR
) (
   // Clock and reset
   input  wire       clk_sys_i,
   input  wire       rst_b_i,
   // Serial register port, open drain data
   input  wire       scl_i,
   input  wire       sda_i,
   output reg        sda_o,
   output reg        sda_oe_o,
   // Straps
   input  wire       cfg_by_serial_i,
   input  wire [2:0] strap_timing_multiplier_i,
   // Analog status, same clock
   input  wire [7:0] temp_code_i,
   input  wire       storage_at_stop_i,
   input  wire [1:0] source_tracking_period_i,
   // Output regulator controls
   output reg        buck_enable_o,
   output reg  [3:0] output_voltage_code_o,
   output reg  [4:0] timing_factor_o,
   // Charger controls
   output reg        charger_enable_o,
   output reg        const_voltage_enable_o,
   output reg  [4:0] charger_stop_voltage_o,
   output reg        charger_charging_o,
   // Boost and monitor controls
   output reg        boost_disable_o,
   output reg  [3:0] monitor_enable_o,
   output reg  [3:0] monitor_power_mode_o,
   output reg        window_short_o
);

   // Serial states
   localparam [3:0] ST_IDLE  = 4'h0;
   localparam [3:0] ST_ADDR  = 4'h1;
   localparam [3:0] ST_AACK  = 4'h2;
   localparam [3:0] ST_REG   = 4'h3;
   localparam [3:0] ST_RACK  = 4'h4;
   localparam [3:0] ST_WDAT  = 4'h5;
   localparam [3:0] ST_WACK  = 4'h6;
   localparam [3:0] ST_RDAT  = 4'h7;
   localparam [3:0] ST_MACK  = 4'h8;

   wire [1:0] line_s;
   wire [1:0] strap_s;
   wire       scl_s;
   wire       sda_s;
   wire       ch_block;
   wire       dis_block;

   reg  [7:0] out_reg;
   reg  [7:0] charger_reg;
   reg  [7:0] ch_cold;
   reg  [7:0] ch_hot;
   reg  [7:0] dis_cold;
   reg  [7:0] dis_hot;
   reg  [7:0] therm_en;
   reg  [7:0] monitor_reg;

   reg        scl_q;
   reg        sda_q;
   reg  [3:0] state;
   reg  [3:0] bit_cnt;
   reg  [7:0] shift;
   reg  [7:0] tx;
   reg  [7:0] pointer;
   reg        rd_mode;
   reg        master_nack;
   reg        wr_pulse;
   reg  [1:0] strap_wait;
   reg        strap_done;
   reg  [7:0] rd_data;
   reg  [4:0] next_factor;

   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;

   // ==========================================
   // Pin synchronisers
   octmc_sync #(.WIDTH(2)) u_line_sync (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .async_i   ({scl_i, sda_i}),
      .sync_o    (line_s)
   );

   octmc_sync #(.WIDTH(2)) u_strap_sync (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .async_i   ({cfg_by_serial_i, 1'b0}),
      .sync_o    (strap_s)
   );

   assign scl_s = line_s[1];
   assign sda_s = line_s[0];

   // ==========================================
   // Thermal window checks
   octmc_window u_charge_window (
      .clk_sys_i    (clk_sys_i),
      .rst_b_i      (rst_b_i),
      .temp_code_i  (temp_code_i),
      .cold_limit_i (ch_cold),
      .hot_limit_i  (ch_hot),
      .guard_en_i   (therm_en[`OCTMC_THERM_EN_BIT]),
      .block_o      (ch_block)
   );

   octmc_window u_discharge_window (
      .clk_sys_i    (clk_sys_i),
      .rst_b_i      (rst_b_i),
      .temp_code_i  (temp_code_i),
      .cold_limit_i (dis_cold),
      .hot_limit_i  (dis_hot),
      .guard_en_i   (therm_en[`OCTMC_THERM_EN_BIT]),
      .block_o      (dis_block)
   );

   // ==========================================
   // Read-back multiplexer, unmapped reads zero
   always @* begin
      case (pointer)
         `OCTMC_OFS_OUT_REG:  rd_data = out_reg;
         `OCTMC_OFS_CHARGER:  rd_data = charger_reg;
         `OCTMC_OFS_CH_COLD:  rd_data = ch_cold;
         `OCTMC_OFS_CH_HOT:   rd_data = ch_hot;
         `OCTMC_OFS_DIS_COLD: rd_data = dis_cold;
         `OCTMC_OFS_DIS_HOT:  rd_data = dis_hot;
         `OCTMC_OFS_THERM_EN: rd_data = therm_en;
         `OCTMC_OFS_MONITOR:  rd_data = monitor_reg;
         default:             rd_data = 8'h00;
      endcase
   end

   // ==========================================
   // Serial slave engine
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_q       <= 1'b1;
         sda_q       <= 1'b1;
         state       <= ST_IDLE;
         bit_cnt     <= 4'h0;
         shift       <= 8'h00;
         tx          <= 8'h00;
         pointer     <= 8'h00;
         rd_mode     <= 1'b0;
         master_nack <= 1'b0;
         wr_pulse    <= 1'b0;
         sda_o       <= 1'b0;
         sda_oe_o    <= 1'b0;
      end else begin
         scl_q    <= scl_s;
         sda_q    <= sda_s;
         wr_pulse <= 1'b0;
         sda_o    <= 1'b0;
         if (start_c) begin
            state    <= ST_ADDR;
            bit_cnt  <= 4'h0;
            sda_oe_o <= 1'b0;
         end else if (stop_c) begin
            state    <= ST_IDLE;
            sda_oe_o <= 1'b0;
         end else if (scl_rise) begin
            if (state == ST_MACK) begin
               master_nack <= sda_s;
               pointer     <= pointer + {7'h00, ~sda_s};  // Advance on master ack only
            end else begin
               shift   <= {shift[6:0], sda_s};
               bit_cnt <= bit_cnt + 4'h1;
            end
         end else if (scl_fall) begin
            case (state)
               ST_ADDR: begin
                  if (bit_cnt == 4'h8) begin
                     if (shift[7:1] == DEV_ADDR) begin
                        rd_mode  <= shift[0];
                        sda_oe_o <= 1'b1;
                        state    <= ST_AACK;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
               end
               ST_AACK: begin
                  bit_cnt <= 4'h0;
                  if (rd_mode) begin
                     tx       <= rd_data;
                     sda_oe_o <= ~rd_data[7];
                     state    <= ST_RDAT;
                  end else begin
                     sda_oe_o <= 1'b0;
                     state    <= ST_REG;
                  end
               end
               ST_REG: begin
                  if (bit_cnt == 4'h8) begin
                     pointer  <= shift;
                     sda_oe_o <= 1'b1;
                     state    <= ST_RACK;
                  end
               end
               ST_RACK: begin
                  sda_oe_o <= 1'b0;
                  bit_cnt  <= 4'h0;
                  state    <= ST_WDAT;
               end
               ST_WDAT: begin
                  if (bit_cnt == 4'h8) begin
                     wr_pulse <= 1'b1;
                     sda_oe_o <= 1'b1;
                     state    <= ST_WACK;
                  end
               end
               ST_WACK: begin
                  sda_oe_o <= 1'b0;
                  pointer  <= pointer + 8'h01;
                  bit_cnt  <= 4'h0;
                  state    <= ST_WDAT;
               end
               ST_RDAT: begin
                  if (bit_cnt == 4'h8) begin
                     sda_oe_o <= 1'b0;
                     state    <= ST_MACK;
                  end else begin
                     tx       <= {tx[6:0], 1'b0};
                     sda_oe_o <= ~tx[6];  // Count advances on clock rise only
                  end
               end
               ST_MACK: begin
                  if (master_nack) begin
                     state <= ST_IDLE;
                  end else begin
                     tx       <= rd_data;
                     sda_oe_o <= ~rd_data[7];
                     bit_cnt  <= 4'h0;
                     state    <= ST_RDAT;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ==========================================
   // Register bank with strap default capture
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_reg     <= `OCTMC_RST_OUT_REG;
         charger_reg <= `OCTMC_RST_CHARGER;
         ch_cold     <= `OCTMC_RST_COLD;
         ch_hot      <= `OCTMC_RST_HOT;
         dis_cold    <= `OCTMC_RST_COLD;
         dis_hot     <= `OCTMC_RST_HOT;
         therm_en    <= `OCTMC_RST_THERM_EN;
         monitor_reg <= `OCTMC_RST_MONITOR;
         strap_wait  <= 2'h0;
         strap_done  <= 1'b0;
      end else begin
         if (!strap_done) begin
            strap_wait <= strap_wait + 2'h1;
            if (strap_wait == `OCTMC_STRAP_WAIT) begin
               strap_done <= 1'b1;
               if (!strap_s[1]) begin
                  out_reg[`OCTMC_TIMING_MULTIPLIER_HI:`OCTMC_TIMING_MULTIPLIER_LO] <= strap_timing_multiplier_i;
               end
            end
         end
         if (wr_pulse) begin
            case (pointer)
               `OCTMC_OFS_OUT_REG:  out_reg     <= shift & `OCTMC_MSK_OUT_REG;
               `OCTMC_OFS_CHARGER:  charger_reg <= shift & `OCTMC_MSK_CHARGER;
               `OCTMC_OFS_CH_COLD:  ch_cold     <= shift;
               `OCTMC_OFS_CH_HOT:   ch_hot      <= shift;
               `OCTMC_OFS_DIS_COLD: dis_cold    <= shift;
               `OCTMC_OFS_DIS_HOT:  dis_hot     <= shift;
               `OCTMC_OFS_THERM_EN: therm_en    <= shift & `OCTMC_MSK_THERM_EN;
               `OCTMC_OFS_MONITOR:  monitor_reg <= shift & `OCTMC_MSK_MONITOR;
               default:             out_reg     <= out_reg;
            endcase
         end
      end
   end

   // ==========================================
   // Timing multiplier code to factor
   always @* begin
      case (out_reg[`OCTMC_TIMING_MULTIPLIER_HI:`OCTMC_TIMING_MULTIPLIER_LO])
         3'h0:    next_factor = 5'h01;
         3'h1:    next_factor = 5'h02;
         3'h2:    next_factor = 5'h03;
         3'h3:    next_factor = 5'h04;
         3'h4:    next_factor = 5'h06;
         3'h5:    next_factor = 5'h08;
         3'h6:    next_factor = 5'h0c;
         default: next_factor = 5'h10;
      endcase
   end

   // ==========================================
   // Converter and charger controls
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         buck_enable_o          <= 1'b0;
         output_voltage_code_o  <= 4'h0;
         timing_factor_o        <= 5'h01;
         charger_enable_o       <= 1'b0;
         const_voltage_enable_o <= 1'b0;
         charger_stop_voltage_o <= 5'h00;
         charger_charging_o     <= 1'b0;
         boost_disable_o        <= 1'b0;
         window_short_o         <= 1'b0;
      end else begin
         // Off codes and hot or cold discharge stop the regulator
         output_voltage_code_o <= out_reg[`OCTMC_VCODE_HI:0];
         buck_enable_o         <= (out_reg[`OCTMC_VCODE_HI:0] != 4'h0) &
                                  (out_reg[`OCTMC_VCODE_HI:0] <= `OCTMC_VCODE_MAX) & ~dis_block;
         timing_factor_o        <= next_factor;
         charger_enable_o       <= charger_reg[`OCTMC_CHG_EN_BIT];
         const_voltage_enable_o <= charger_reg[`OCTMC_CHG_CV_BIT];
         charger_stop_voltage_o <= charger_reg[`OCTMC_STOP_HI:`OCTMC_STOP_LO];
         charger_charging_o     <= charger_reg[`OCTMC_CHG_EN_BIT] & ~ch_block &
                                   ~(charger_reg[`OCTMC_CHG_CV_BIT] & storage_at_stop_i);
         boost_disable_o        <= ch_block;
         window_short_o         <= monitor_reg[`OCTMC_MON_WIN_BIT] |
                                   (|source_tracking_period_i);
      end
   end

   // ==========================================
   // Per-channel monitor enable and mode
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch = ch + 1) begin : g_mon
         always @(posedge clk_sys_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               monitor_enable_o[ch]     <= 1'b0;
               monitor_power_mode_o[ch] <= 1'b0;
            end else begin
               monitor_enable_o[ch]     <= monitor_reg[ch];
               monitor_power_mode_o[ch] <= monitor_reg[`OCTMC_MON_MODE_BIT] &
                                           (ch != `OCTMC_MON_CHG_CH);
            end
         end
      end
   endgenerate

endmodule

// ### core/octmc_defs.vh
// Constants for the output, charger, thermal and monitor configuration bank.
// Assumes byte registers reached through the serial register port.
`ifndef OCTMC_DEFS_VH
`define OCTMC_DEFS_VH

// ==========================================
// Register offsets
`define OCTMC_OFS_OUT_REG      8'h0a
`define OCTMC_OFS_CHARGER      8'h0c
`define OCTMC_OFS_CH_COLD      8'h0d
`define OCTMC_OFS_CH_HOT       8'h0e
`define OCTMC_OFS_DIS_COLD     8'h0f
`define OCTMC_OFS_DIS_HOT      8'h10
`define OCTMC_OFS_THERM_EN     8'h11
`define OCTMC_OFS_MONITOR      8'h13

// ==========================================
// Reset values
`define OCTMC_RST_OUT_REG      8'h30
`define OCTMC_RST_CHARGER      8'h01
`define OCTMC_RST_COLD         8'hd1
`define OCTMC_RST_HOT          8'h18
`define OCTMC_RST_THERM_EN     8'h01
`define OCTMC_RST_MONITOR      8'h00

// ==========================================
// Writable bit masks, reserved bits cleared
`define OCTMC_MSK_OUT_REG      8'h7f
`define OCTMC_MSK_CHARGER      8'h7f
`define OCTMC_MSK_THERM_EN     8'h01
`define OCTMC_MSK_MONITOR      8'h3f

// ==========================================
// Field positions
`define OCTMC_VCODE_HI         3
`define OCTMC_TIMING_MULTIPLIER_HI         6
`define OCTMC_TIMING_MULTIPLIER_LO         4
`define OCTMC_VCODE_MAX        4'ha
`define OCTMC_CHG_EN_BIT       0
`define OCTMC_CHG_CV_BIT       1
`define OCTMC_STOP_HI          6
`define OCTMC_STOP_LO          2
`define OCTMC_THERM_EN_BIT     0
`define OCTMC_MON_MODE_BIT     4
`define OCTMC_MON_WIN_BIT      5
`define OCTMC_MON_CHG_CH       3

// ==========================================
// Serial port defaults and power-up wait
`define OCTMC_DEV_ADDR         7'h2a
`define OCTMC_STRAP_WAIT       2'h3

`endif

// ### core/octmc_sync.v
// Two-flop synchroniser for asynchronous level inputs.
// Assumes inputs are levels that stay stable for several clocks.
`timescale 1ns/1ps
module octmc_sync #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input  wire             clk_sys_i,
   input  wire             rst_b_i,
   // Data
   input  wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] stage_a;
   reg [WIDTH-1:0] stage_b;

   // ==========================================
   // Two flip-flop stages
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stage_a <= {WIDTH{1'b1}};  // Idle high level, no false edge
         stage_b <= {WIDTH{1'b1}};
      end else begin
         stage_a <= async_i;
         stage_b <= stage_a;
      end
   end

   assign sync_o = stage_b;

endmodule

// ### core/octmc_window.v
// Thermistor code window check against a cold and a hot limit.
// Assumes codes rise as temperature falls (NTC divider).
`timescale 1ns/1ps
module octmc_window (
   // Clock and reset
   input  wire       clk_sys_i,
   input  wire       rst_b_i,
   // Codes
   input  wire [7:0] temp_code_i,
   input  wire [7:0] cold_limit_i,
   input  wire [7:0] hot_limit_i,
   input  wire       guard_en_i,
   // Result
   output reg        block_o
);

   // ==========================================
   // Outside window while guarding blocks the path
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         block_o <= 1'b0;
      end else begin
         block_o <= guard_en_i & ((temp_code_i > cold_limit_i) | (temp_code_i < hot_limit_i));
      end
   end

endmodule

// ### test/octmc_monitor.sv
// Checker on the configuration bank ports.
// Assumes binding into octmc_top, one clock domain.
`timescale 1ns/1ps
module octmc_monitor (
   // Clock and reset
   input wire       clk_sys_i,
   input wire       rst_b_i,
   // Serial and status
   input wire       scl_i,
   input wire       sda_oe_o,
   input wire       storage_at_stop_i,
   input wire [1:0] source_tracking_period_i,
   // Controls
   input wire       buck_enable_o,
   input wire [3:0] output_voltage_code_o,
   input wire [4:0] timing_factor_o,
   input wire       charger_enable_o,
   input wire       const_voltage_enable_o,
   input wire       charger_charging_o,
   input wire       boost_disable_o,
   input wire [3:0] monitor_power_mode_o,
   input wire       window_short_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   // ====
   // Port relations
   property p_vcode; buck_enable_o |-> output_voltage_code_o inside {[4'h1:4'ha]}; endproperty
   a_vcode: assert property (p_vcode) else $error("buck on with off code");
   property p_factor; timing_factor_o inside {5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10}; endproperty
   a_factor: assert property (p_factor) else $error("bad timing factor");
   property p_chg_en; charger_charging_o |-> charger_enable_o; endproperty
   a_chg_en: assert property (p_chg_en) else $error("charging while disabled");
   property p_cv_stop; (const_voltage_enable_o && storage_at_stop_i) [*2] |-> !charger_charging_o; endproperty
   a_cv_stop: assert property (p_cv_stop) else $error("charging past stop level");
   property p_chg_cnt; monitor_power_mode_o[3] == 1'b0; endproperty
   a_chg_cnt: assert property (p_chg_cnt) else $error("charger channel not counting");
   property p_mode_all; monitor_power_mode_o[2:0] == {3{monitor_power_mode_o[0]}}; endproperty
   a_mode_all: assert property (p_mode_all) else $error("channel modes differ");
   property p_force; (source_tracking_period_i != 2'h0) [*3] |-> window_short_o; endproperty
   a_force: assert property (p_force) else $error("short window not forced");
   property p_ack_low; $rose(sda_oe_o) |-> !scl_i && !$past(scl_i, 2); endproperty
   a_ack_low: assert property (p_ack_low) else $error("data driven in clock high");
   property p_boost; boost_disable_o |-> !charger_charging_o; endproperty
   a_boost: assert property (p_boost) else $error("charging while boost blocked");
   // Main scenarios
   c_boost: cover property ($rose(boost_disable_o));
   c_short: cover property ($rose(window_short_o));
   c_buck: cover property ($rose(buck_enable_o));
endmodule

// ### test/octmc_host.sv
// Serial host model: byte writes and pointer reads.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
`include "octmc_defs.vh"
module octmc_host #(
   parameter [6:0] DEV_ADDR = `OCTMC_DEV_ADDR
) (
   // Clock
   input  wire clk_i,
   // Serial line
   input  wire sda_i,
   output reg  scl_o,
   output reg  pull_o
);
   reg [7:0] rd_buf [0:15];
   // ====
   // Idle line, then five-clock phases
   initial begin
      scl_o = 1'b1;
      pull_o = 1'b0;
   end
   task hp;
      repeat (5) @(posedge clk_i);
   endtask
   // Bit: data moves in low phase, sampled before fall
   task bitx(input b, output r);
      begin
         hp;
         pull_o <= ~b;
         hp;
         scl_o <= 1'b1;
         hp;
         r = sda_i;
         scl_o <= 1'b0;
      end
   endtask
   // Start or repeated start
   task strt;
      begin
         hp;
         pull_o <= 1'b0;
         hp;
         scl_o <= 1'b1;
         hp;
         pull_o <= 1'b1;
         hp;
         scl_o <= 1'b0;
      end
   endtask
   // Stop, data rises with clock high
   task stp;
      begin
         hp;
         pull_o <= 1'b1;
         hp;
         scl_o <= 1'b1;
         hp;
         pull_o <= 1'b0;
         hp;
      end
   endtask
   // Byte out, MSB first
   task tx(input [7:0] d, output ack);
      integer k;
      reg     r;
      begin
         for (k = 7; k >= 0; k = k - 1)
            bitx(d[k], r);
         bitx(1'b1, r);
         ack = ~r;
      end
   endtask
   // Byte in, last one refused
   task rx(input last, output [7:0] d);
      integer k;
      reg     r;
      begin
         for (k = 7; k >= 0; k = k - 1) begin
            bitx(1'b1, r);
            d[k] = r;
         end
         bitx(last, r);
      end
   endtask
   task wr(input [6:0] a, input [7:0] p, input [7:0] d, output ok);
      reg k0, k1, k2;
      begin
         strt;
         tx({a, 1'b0}, k0);
         tx(p, k1);
         tx(d, k2);
         stp;
         ok = k0 & k1 & k2;
      end
   endtask
   task rd(input [7:0] p, input integer n, output ok);
      integer j;
      reg     k0, k1, k2;
      begin
         strt;
         tx({DEV_ADDR, 1'b0}, k0);
         tx(p, k1);
         strt;
         tx({DEV_ADDR, 1'b1}, k2);
         for (j = 0; j < n; j = j + 1)
            rx(j == n - 1, rd_buf[j]);
         stp;
         ok = k0 & k1 & k2;
      end
   endtask
endmodule

// ### test/octmc_top_tb.sv
// Bench for the configuration bank over the serial port.
// Assumes octmc_host drives the line and octmc_monitor is bound.
`timescale 1ns/1ps
`include "octmc_defs.vh"
module octmc_top_tb;
   reg        clk_sys_i;
   reg        rst_b_i;
   reg        cfg_by_serial_i;
   reg  [2:0] strap_timing_multiplier_i;
   reg  [7:0] temp_code_i;
   reg        storage_at_stop_i;
   reg  [1:0] source_tracking_period_i;
   wire       scl_i;
   wire       sda_i;
   wire       host_pull;
   wire       sda_o;
   wire       sda_oe_o;
   wire       buck_enable_o;
   wire [3:0] output_voltage_code_o;
   wire [4:0] timing_factor_o;
   wire       charger_enable_o;
   wire       const_voltage_enable_o;
   wire [4:0] charger_stop_voltage_o;
   wire       charger_charging_o;
   wire       boost_disable_o;
   wire [3:0] monitor_enable_o;
   wire [3:0] monitor_power_mode_o;
   wire       window_short_o;
   integer    failures;
   integer    n_checks;
   integer    cycles;
   integer    i;
   reg        ok;
   localparam [79:0] RST_TAB  = 80'h30_00_01_d1_18_d1_18_01_00_00;
   localparam [63:0] FACT_TAB = 64'h10_0c_08_06_04_03_02_01;
   // ====
   // Design, host and pulled-up data line
   assign sda_i = ~(host_pull | sda_oe_o);
   octmc_top u_octmc_top (.*);
   octmc_host u_octmc_host (.clk_i(clk_sys_i), .sda_i(sda_i), .scl_o(scl_i), .pull_o(host_pull));
   // Clock and cycle ceiling
   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         failures = failures + 1;
         end_of_test;
      end
   end
   // ====
   // Shared tasks
   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task settle;
      begin
         repeat (4) @(posedge clk_sys_i);
         #1;
      end
   endtask
   task wr(input [7:0] p, input [7:0] d);
      begin
         u_octmc_host.wr(`OCTMC_DEV_ADDR, p, d, ok);
         chk({7'h0, ok}, 8'h01);
      end
   endtask
   task rd1(input [7:0] p, input [7:0] exp);
      begin
         u_octmc_host.rd(p, 1, ok);
         chk({7'h0, ok}, 8'h01);
         chk(u_octmc_host.rd_buf[0], exp);
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d failures %0d", n_checks, failures);
         if (failures == 0 && n_checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   // ====
   // Test sequence
   initial begin
      failures = 0;
      n_checks = 0;
      cycles = 0;
      rst_b_i = 1'b0;
      cfg_by_serial_i = 1'b1;
      strap_timing_multiplier_i = 3'h0;
      temp_code_i = 8'h80;
      storage_at_stop_i = 1'b0;
      source_tracking_period_i = 2'h0;
      repeat (12) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      settle;
      settle;
      // Reset values, gaps read zero
      chk({3'h0, timing_factor_o}, 8'h04);
      chk({6'h0, sda_o, sda_oe_o}, 8'h00);
      u_octmc_host.rd(8'h0a, 10, ok);
      chk({7'h0, ok}, 8'h01);
      for (i = 0; i < 10; i = i + 1)
         chk(u_octmc_host.rd_buf[i], RST_TAB[79 - 8 * i -: 8]);
      $display("reset test done");
      // Regulator off codes, then each multiplier with a live code
      wr(8'h0a, 8'hff);
      rd1(8'h0a, 8'h7f);
      chk({7'h0, buck_enable_o}, 8'h00);
      wr(8'h0a, 8'h0b);
      chk({7'h0, buck_enable_o}, 8'h00);
      for (i = 0; i < 10; i = i + 1) begin
         wr(8'h0a, {1'b1, i[2:0], i[3:0] + 4'h1});
         chk({3'h0, buck_enable_o, output_voltage_code_o}, {4'h1, i[3:0] + 4'h1});
         chk({3'h0, timing_factor_o}, FACT_TAB[8 * i[2:0] +: 8]);
      end
      $display("regulator test done");
      // Charger enable and constant-voltage stop
      wr(8'h0c, 8'hff);
      rd1(8'h0c, 8'h7f);
      chk({5'h0, charger_enable_o, const_voltage_enable_o, charger_charging_o}, 8'h07);
      chk({3'h0, charger_stop_voltage_o}, 8'h1f);
      storage_at_stop_i <= 1'b1;
      settle;
      chk({7'h0, charger_charging_o}, 8'h00);
      wr(8'h0c, 8'h01);
      chk({3'h0, charger_stop_voltage_o}, 8'h00);
      chk({7'h0, charger_charging_o}, 8'h01);
      wr(8'h0c, 8'h00);
      chk({6'h0, charger_enable_o, charger_charging_o}, 8'h00);
      storage_at_stop_i <= 1'b0;
      $display("charger test done");
      // Thermal guard, charge window narrowed
      wr(8'h0d, 8'((256 * 10000) / (10000 + 10000)));
      temp_code_i <= 8'h90;
      settle;
      chk({6'h0, boost_disable_o, buck_enable_o}, 8'h03);
      temp_code_i <= 8'he0;
      settle;
      chk({6'h0, boost_disable_o, buck_enable_o}, 8'h02);
      temp_code_i <= 8'h10;
      settle;
      chk({6'h0, boost_disable_o, buck_enable_o}, 8'h02);
      wr(8'h11, 8'hfe);
      chk({6'h0, boost_disable_o, buck_enable_o}, 8'h01);
      rd1(8'h11, 8'h00);
      wr(8'h11, 8'h01);
      chk({6'h0, boost_disable_o, buck_enable_o}, 8'h02);
      temp_code_i <= 8'h80;
      $display("thermal test done");
      // Monitor enables, shared mode, window and forcing
      wr(8'h13, 8'hdf);
      rd1(8'h13, 8'h1f);
      chk({monitor_enable_o, monitor_power_mode_o}, 8'hf7);
      chk({7'h0, window_short_o}, 8'h00);
      wr(8'h13, 8'h20);
      chk({monitor_enable_o, monitor_power_mode_o}, 8'h00);
      chk({7'h0, window_short_o}, 8'h01);
      wr(8'h13, 8'h00);
      chk({7'h0, window_short_o}, 8'h00);
      for (i = 1; i < 4; i = i + 1) begin
         source_tracking_period_i <= i[1:0];
         settle;
         chk({7'h0, window_short_o}, 8'h01);
      end
      source_tracking_period_i <= 2'h0;
      $display("monitor test done");
      // Foreign address refused, unmapped write ignored
      u_octmc_host.wr(`OCTMC_DEV_ADDR ^ 7'h01, 8'h0a, 8'h01, ok);
      chk({7'h0, ok}, 8'h00);
      rd1(8'h0a, 8'h1a);
      wr(8'h12, 8'h55);
      rd1(8'h12, 8'h00);
      $display("refusal test done");
      // Strap configuration after a second reset
      cfg_by_serial_i <= 1'b0;
      strap_timing_multiplier_i <= 3'h6;
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      settle;
      settle;
      chk({3'h0, timing_factor_o}, 8'h0c);
      rd1(8'h0a, 8'h60);
      $display("strap test done");
      end_of_test;
   end
endmodule
bind octmc_top octmc_monitor u_octmc_monitor (.*);
